// *** src/mpfc_flow_ctrl.v ***
// pause and back pressure flow control with its apb register file
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

`include "mpfc_regs.vh"

module mpfc_flow_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // station address used as pause frame source
    input  wire [47:0] mac_src_addr,
    // control frame towards the mac transmitter
    output reg         ctl_tx_valid,
    output reg  [7:0]  ctl_tx_data,
    output reg         ctl_tx_last,
    input  wire        ctl_tx_ready,
    input  wire        ctl_tx_done,
    // received byte stream from the mac receiver
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_sof,
    input  wire        rx_eof,
    input  wire        rx_good,
    // received data and status towards the application
    output reg         app_rx_valid,
    output reg  [7:0]  app_rx_data,
    output reg         app_rx_eof,
    output reg         app_stat_valid,
    output reg         app_stat_good,
    output reg         app_stat_filter,
    // transmit hold and back pressure
    output wire        tx_pause_hold,
    output reg         back_pressure
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SEND = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;

    localparam [31:0] FLOW_RST = `MPFC_FLOW_RST;
    localparam [47:0] CTL_DA   = `MPFC_CTL_DA;
    localparam [15:0] CTL_TYPE = `MPFC_CTL_TYPE;
    localparam [15:0] CTL_OP   = `MPFC_CTL_OPCODE;

    reg  [15:0] quanta_q;
    reg         fwd_q;
    reg         en_q;
    reg  [1:0]  afc_q;
    reg  [2:0]  link_q;
    reg  [1:0]  st_q;
    reg  [5:0]  tx_idx_q;
    reg  [4:0]  rx_idx_q;
    reg         rx_match_q;
    reg  [15:0] rx_time_q;
    reg         pause_load_q;
    wire [15:0] pause_left;

    wire tx_en     = link_q[`MPFC_LINK_TXEN_BIT];
    wire full_dup  = link_q[`MPFC_LINK_FD_BIT];
    wire [9:0] idx = paddr[11:2];
    wire apb_acc   = psel && penable && !pready;
    wire apb_wr    = apb_acc && pwrite;
    wire busy      = (st_q != ST_IDLE) || back_pressure;

    wire hit_flow  = (idx == {2'b00, `MPFC_FLOW_IDX});
    wire hit_afc   = (idx == {2'b00, `MPFC_AFC_IDX});
    wire hit_link  = (idx == {2'b00, `MPFC_LINK_IDX});
    wire hit_stat  = (idx == {2'b00, `MPFC_STAT_IDX});
    wire hit_any   = hit_flow || hit_afc || hit_link || hit_stat;

    // register writes; the busy position is never stored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quanta_q <= FLOW_RST[`MPFC_QUANTA_HI:`MPFC_QUANTA_LO];
            fwd_q    <= 1'b0;
            en_q     <= 1'b0;
            afc_q    <= `MPFC_AFC_RST;
            link_q   <= `MPFC_LINK_RST;
        end else if (ce) begin
            if (apb_wr && hit_flow) begin
                quanta_q <= pwdata[`MPFC_QUANTA_HI:`MPFC_QUANTA_LO];
                fwd_q    <= pwdata[`MPFC_FWD_BIT];
                en_q     <= pwdata[`MPFC_EN_BIT];
            end
            if (apb_wr && hit_afc) begin
                afc_q <= pwdata[1:0];
            end else if (st_q == ST_SEND) begin
                // a send request is consumed once the frame starts
                afc_q[`MPFC_AFC_SEND_BIT] <= 1'b0;
            end
            if (apb_wr && hit_link) begin
                link_q <= pwdata[2:0];
            end
        end
    end

    // apb answer with one wait state; unmapped words answer with an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= apb_acc;
            pslverr <= apb_acc && !hit_any;
            if (apb_acc && !pwrite) begin
                if (hit_flow) begin
                    prdata <= {quanta_q, 13'h0000, fwd_q, en_q, busy};
                end else if (hit_afc) begin
                    prdata <= {30'h00000000, afc_q};
                end else if (hit_link) begin
                    prdata <= {29'h00000000, link_q};
                end else if (hit_stat) begin
                    prdata <= {pause_left, 14'h0000, tx_pause_hold,
                               back_pressure};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

    // half duplex back pressure, only with the transmitter on
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            back_pressure <= 1'b0;
        end else if (ce) begin
            back_pressure <= !full_dup && en_q && tx_en
                             && afc_q[`MPFC_AFC_BP_BIT];
        end
    end

    // pause frame byte picker: da, sa, type, opcode, time, zero pad
    function [7:0] frame_byte;
        input [5:0]  i;
        input [47:0] sa;
        input [15:0] pt;
        begin
            case (i)
                6'h00: frame_byte = CTL_DA[47:40];
                6'h01: frame_byte = CTL_DA[39:32];
                6'h02: frame_byte = CTL_DA[31:24];
                6'h03: frame_byte = CTL_DA[23:16];
                6'h04: frame_byte = CTL_DA[15:8];
                6'h05: frame_byte = CTL_DA[7:0];
                6'h06: frame_byte = sa[47:40];
                6'h07: frame_byte = sa[39:32];
                6'h08: frame_byte = sa[31:24];
                6'h09: frame_byte = sa[23:16];
                6'h0a: frame_byte = sa[15:8];
                6'h0b: frame_byte = sa[7:0];
                6'h0c: frame_byte = CTL_TYPE[15:8];
                6'h0d: frame_byte = CTL_TYPE[7:0];
                6'h0e: frame_byte = CTL_OP[15:8];
                6'h0f: frame_byte = CTL_OP[7:0];
                6'h10: frame_byte = pt[15:8];
                6'h11: frame_byte = pt[7:0];
                default: frame_byte = 8'h00;
            endcase
        end
    endfunction

    wire tx_adv = !ctl_tx_valid || ctl_tx_ready;

    // full duplex pause frame sender; the mac appends the crc
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q         <= ST_IDLE;
            tx_idx_q     <= 6'h00;
            ctl_tx_valid <= 1'b0;
            ctl_tx_data  <= 8'h00;
            ctl_tx_last  <= 1'b0;
        end else if (ce) begin
            case (st_q)
                ST_IDLE: begin
                    tx_idx_q <= 6'h00;
                    if (afc_q[`MPFC_AFC_SEND_BIT] && full_dup && tx_en) begin
                        st_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (tx_adv) begin
                        ctl_tx_valid <= 1'b1;
                        ctl_tx_data  <= frame_byte(tx_idx_q, mac_src_addr,
                                                   quanta_q);
                        ctl_tx_last  <= (tx_idx_q == `MPFC_FRAME_LAST);
                        tx_idx_q     <= tx_idx_q + 6'h01;
                        if (tx_idx_q == `MPFC_FRAME_LAST) begin
                            st_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (ctl_tx_ready) begin
                        ctl_tx_valid <= 1'b0;
                        ctl_tx_last  <= 1'b0;
                    end
                    // busy holds until the wire reports the frame gone
                    if (ctl_tx_done) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // receive side: data always forwarded, pause decoded only when enabled
    wire decode_on = en_q && full_dup;
    wire [4:0] rx_pos = rx_sof ? 5'h00 : rx_idx_q;
    reg  [7:0] want;

    always @* begin
        case (rx_pos)
            5'h00: want = CTL_DA[47:40];
            5'h01: want = CTL_DA[39:32];
            5'h02: want = CTL_DA[31:24];
            5'h03: want = CTL_DA[23:16];
            5'h04: want = CTL_DA[15:8];
            5'h05: want = CTL_DA[7:0];
            5'h0c: want = CTL_TYPE[15:8];
            5'h0d: want = CTL_TYPE[7:0];
            5'h0e: want = CTL_OP[15:8];
            5'h0f: want = CTL_OP[7:0];
            default: want = rx_data;
        endcase
    end

    wire match_now = (rx_sof || rx_match_q) && (rx_data == want);
    wire is_pause  = decode_on && match_now && (rx_idx_q > 5'h11);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_idx_q        <= 5'h00;
            rx_match_q      <= 1'b0;
            rx_time_q       <= 16'h0000;
            pause_load_q    <= 1'b0;
            app_rx_valid    <= 1'b0;
            app_rx_data     <= 8'h00;
            app_rx_eof      <= 1'b0;
            app_stat_valid  <= 1'b0;
            app_stat_good   <= 1'b0;
            app_stat_filter <= 1'b0;
        end else if (ce) begin
            app_rx_valid   <= rx_valid;
            app_rx_data    <= rx_data;
            app_rx_eof     <= rx_valid && rx_eof;
            app_stat_valid <= rx_valid && rx_eof;
            pause_load_q   <= 1'b0;
            if (rx_valid) begin
                if (rx_pos != 5'h1f) begin
                    rx_idx_q <= rx_pos + 5'h01;
                end
                rx_match_q <= match_now;
                if (rx_pos == 5'h10) begin
                    rx_time_q[15:8] <= rx_data;
                end
                if (rx_pos == 5'h11) begin
                    rx_time_q[7:0] <= rx_data;
                end
                if (rx_eof) begin
                    app_stat_good   <= rx_good;
                    app_stat_filter <= fwd_q && rx_good && is_pause;
                    pause_load_q    <= rx_good && is_pause;
                end
            end
        end
    end

    // stops the transmitter for the decoded quanta
    mpfc_pause_timer u_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .load      (pause_load_q),
        .quanta    (rx_time_q),
        .speed_100 (link_q[`MPFC_LINK_SPD_BIT]),
        .hold_q    (tx_pause_hold),
        .left_q    (pause_left)
    );

endmodule // mpfc_flow_ctrl

`default_nettype wire

// *** src/mpfc_regs.vh ***
// register map, field positions and timing counts of the pause flow control
`ifndef MPFC_REGS_VH
`define MPFC_REGS_VH

// register indices; byte address is four times the index
`define MPFC_FLOW_IDX        8'h08
`define MPFC_AFC_IDX         8'h10
`define MPFC_LINK_IDX        8'h11
`define MPFC_STAT_IDX        8'h12

`define MPFC_FLOW_RST        32'h00000000
`define MPFC_AFC_RST         2'h0
`define MPFC_LINK_RST        3'h0

// pause_flow_setting fields
`define MPFC_QUANTA_HI       31
`define MPFC_QUANTA_LO       16
`define MPFC_FWD_BIT         2
`define MPFC_EN_BIT          1
`define MPFC_BUSY_BIT        0

// auto_flow_request_cfg fields
`define MPFC_AFC_SEND_BIT    0
`define MPFC_AFC_BP_BIT      1

// link control fields
`define MPFC_LINK_TXEN_BIT   0
`define MPFC_LINK_FD_BIT     1
`define MPFC_LINK_SPD_BIT    2

// pause frame constants
`define MPFC_CTL_DA          48'h0180c2000001
`define MPFC_CTL_TYPE        16'h8808
`define MPFC_CTL_OPCODE      16'h0001
`define MPFC_FRAME_LAST      6'h3b

// one pause quantum is 512 bit times
`define MPFC_CLK_NS          100
`define MPFC_QUANTUM_10_NS   51200
`define MPFC_QUANTUM_100_NS  5120
`define MPFC_Q10_CYC  ((`MPFC_QUANTUM_10_NS + `MPFC_CLK_NS - 1) / `MPFC_CLK_NS)
`define MPFC_Q100_CYC ((`MPFC_QUANTUM_100_NS + `MPFC_CLK_NS - 1) / `MPFC_CLK_NS)

`endif

// *** src/mpfc_pause_timer.v ***
// transmit hold-off timer counting pause quanta of 512 bit times
`timescale 1ns/10ps
`default_nettype none

`include "mpfc_regs.vh"

module mpfc_pause_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        load,
    input  wire [15:0] quanta,
    input  wire        speed_100,
    output reg         hold_q,
    output reg  [15:0] left_q
);

    localparam [31:0] Q10_W  = `MPFC_Q10_CYC;
    localparam [31:0] Q100_W = `MPFC_Q100_CYC;
    localparam [9:0]  Q10    = Q10_W[9:0];
    localparam [9:0]  Q100   = Q100_W[9:0];

    reg  [9:0] sub_q;
    wire [9:0] sub_top = speed_100 ? Q100 - 10'h001 : Q10 - 10'h001;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_q  <= 10'h000;
            left_q <= 16'h0000;
            hold_q <= 1'b0;
        end else if (ce) begin
            if (load) begin
                // a fresh frame reloads; zero releases at once
                sub_q  <= sub_top;
                left_q <= quanta;
                hold_q <= (quanta != 16'h0000);
            end else if (left_q != 16'h0000) begin
                if (sub_q == 10'h000) begin
                    sub_q  <= sub_top;
                    left_q <= left_q - 16'h0001;
                    hold_q <= (left_q != 16'h0001);
                end else begin
                    sub_q <= sub_q - 10'h001;
                end
            end
        end
    end

endmodule // mpfc_pause_timer

`default_nettype wire

// *** dv/mpfc_link_partner.sv ***
// remote link partner model: takes pause frames, sends receive frames
`timescale 1ns/10ps
`default_nettype none
`include "mpfc_regs.vh"
module mpfc_link_partner #(
    parameter logic [47:0] SA = 48'h020000000001
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    input  wire logic       ctl_tx_valid,
    input  wire logic [7:0] ctl_tx_data,
    input  wire logic       ctl_tx_last,
    output logic            ctl_tx_ready,
    output logic            ctl_tx_done,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_sof,
    output logic            rx_eof,
    output logic            rx_good
);
    logic [6:0] nb;
    logic [7:0] frm [0:63];
    logic [2:0] dly;
    logic [1:0] ph;
    initial begin
        {rx_valid, rx_sof, rx_eof, rx_good} = 4'h0;
        rx_data = 8'h5a;
    end
    // slow mode takes one byte in four, so each byte must be held
    assign ctl_tx_ready = !slow || ph == 2'd0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nb <= 7'd0;
            ph <= 2'd0;
            dly <= 3'd0;
            ctl_tx_done <= 1'b0;
        end else begin
            ph <= ph + 2'd1;
            ctl_tx_done <= dly == 3'd1;
            if (dly != 3'd0) dly <= dly - 3'd1;
            if (ctl_tx_valid && ctl_tx_ready) begin
                frm[nb[5:0]] <= ctl_tx_data;
                nb <= nb + 7'd1;
                // completion only after the wire has carried the last byte
                if (ctl_tx_last) dly <= 3'd4;
            end
        end
    end
    function automatic logic [7:0] fbyte(input int i, input logic [15:0] pt,
                                         input logic [15:0] ty);
        logic [159:0] h;
        h = {`MPFC_CTL_DA, SA, ty, `MPFC_CTL_OPCODE, pt, 16'h0000};
        fbyte = (i < 20) ? h[159 - 8 * i -: 8] : 8'h00;
    endfunction
    task send(input logic [15:0] pt, input logic [15:0] ty, input logic good);
        begin
            for (int i = 0; i < 60; i++) begin
                @(posedge pclk);
                rx_valid <= 1'b1;
                rx_data <= fbyte(i, pt, ty);
                rx_sof <= i == 0;
                rx_eof <= i == 59;
                rx_good <= good && i == 59;
            end
            @(posedge pclk);
            {rx_valid, rx_sof, rx_eof, rx_good} <= 4'h0;
            // idle data lines do not keep the last byte
            rx_data <= ~fbyte(59, pt, ty);
        end
    endtask
endmodule // mpfc_link_partner
`default_nettype wire

// *** dv/mpfc_flow_chk.sv ***
// assertion checker on the pause flow control ports
`timescale 1ns/10ps
`default_nettype none
`include "mpfc_regs.vh"
module mpfc_flow_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ctl_tx_valid,
    input wire logic [7:0]  ctl_tx_data,
    input wire logic        ctl_tx_last,
    input wire logic        ctl_tx_ready,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        app_rx_valid,
    input wire logic [7:0]  app_rx_data,
    input wire logic        app_stat_valid,
    input wire logic        app_stat_filter,
    input wire logic        tx_pause_hold,
    input wire logic        back_pressure
);
    logic [31:0] flow_q;
    logic [2:0]  link_q;
    logic [5:0]  cnt_q;
    logic        wr;
    assign wr = psel && penable && pwrite && !pready && ce;
    // shadows update on the same edge as the register file
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_q <= 32'h00000000;
            link_q <= 3'h0;
            cnt_q <= 6'h00;
        end else begin
            if (wr && paddr[11:2] == `MPFC_FLOW_IDX) flow_q <= pwdata;
            if (wr && paddr[11:2] == `MPFC_LINK_IDX) link_q <= pwdata[2:0];
            if (ctl_tx_valid && ctl_tx_ready)
                cnt_q <= ctl_tx_last ? 6'h00 : cnt_q + 6'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_DA_FIRST: assert property (ctl_tx_valid && cnt_q == 6'h00 |->
        ctl_tx_data == 8'h01) else $error("pause frame first byte wrong");
    AST_TYPE_HI: assert property (ctl_tx_valid && cnt_q == 6'h0c |->
        ctl_tx_data == 8'h88) else $error("pause frame type byte wrong");
    AST_TIME: assert property (ctl_tx_valid && cnt_q[5:1] == 5'h08 |->
        ctl_tx_data == (cnt_q[0] ? flow_q[23:16] : flow_q[31:24]))
        else $error("pause time byte differs from register");
    AST_LAST: assert property (ctl_tx_valid |->
        ctl_tx_last == (cnt_q == 6'h3b)) else $error("last flag misplaced");
    AST_HOLD_BYTE: assert property (ctl_tx_valid && !ctl_tx_ready |=>
        ctl_tx_valid && $stable(ctl_tx_data)) else $error("byte not held");
    AST_TX_OFF: assert property (!link_q[0] |->
        !ctl_tx_valid && !back_pressure) else $error("activity with tx off");
    AST_APP_PASS: assert property (rx_valid |=> app_rx_valid &&
        app_rx_data == $past(rx_data)) else $error("rx byte not passed on");
    AST_FILT_OFF: assert property (app_stat_valid && !flow_q[2] |->
        !app_stat_filter) else $error("filter flag set with marker clear");
    AST_NO_PAUSE: assert property ($rose(tx_pause_hold) |->
        flow_q[1] && link_q[1]) else $error("pause without enable");
    AST_BP_HALF: assert property ($rose(back_pressure) |->
        flow_q[1] && !link_q[1]) else $error("back pressure out of mode");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error response without ready");
endmodule // mpfc_flow_chk
bind mpfc_flow_ctrl mpfc_flow_chk mpfc_flow_chk_i (.*);
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the pause flow control block
`timescale 1ns/10ps
`default_nettype none
`include "mpfc_regs.vh"
module testbench;
    localparam logic [47:0] SA = 48'h02a1b2c3d4e5;
    localparam logic [15:0] PT = `MPFC_CTL_TYPE;
    logic        pclk = 0, presetn = 0, ce = 1, slow = 1;
    logic        psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [47:0] mac_src_addr = SA;
    logic        pready, pslverr, ctl_tx_valid, ctl_tx_last, ctl_tx_ready;
    logic        ctl_tx_done, rx_valid, rx_sof, rx_eof, rx_good, app_rx_valid;
    logic [7:0]  ctl_tx_data, rx_data, app_rx_data;
    logic        app_rx_eof, app_stat_valid, app_stat_good, app_stat_filter;
    logic        tx_pause_hold, back_pressure, st_filt, st_good;
    integer      num_errors = 0, cmp_count = 0, app_n = 0, hold_n = 0;
    integer      eof_n = 0;
    mpfc_flow_ctrl mpfc_flow_ctrl_i (.*);
    mpfc_link_partner #(.SA(SA)) mpfc_link_partner_i (.*);
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        if (app_rx_valid) app_n <= app_n + 1;
        if (tx_pause_hold) hold_n <= hold_n + 1;
        if (app_rx_eof) eof_n <= eof_n + 1;
        if (app_stat_valid) {st_filt, st_good} <= {app_stat_filter, app_stat_good};
    end
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        integer n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        {rd, err} = {prdata, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin num_errors++; end_of_test; end
        @(posedge pclk);
    endtask
    // waits for a clear busy flag so a write never races a frame
    task wflow(input logic [31:0] v);
        integer n;
        n = 0;
        do begin apb(0, `MPFC_FLOW_IDX, 0); n++; end while (rd[0] !== 1'b0 && n < 99);
        apb(1, `MPFC_FLOW_IDX, v & 32'hfffffffe);
    endtask
    task rx_case(input logic [15:0] pt, ty, input logic good, input integer hx,
                 input logic fx);
        integer a, h, e;
        {a, h, e} = {app_n, hold_n, eof_n};
        mpfc_link_partner_i.send(pt, ty, good);
        tick(hx + 10);
        check("app bytes", app_n - a, 60);
        check("app eof", eof_n - e, 1);
        check("stat good", st_good, good);
        check("filter", st_filt, fx);
        check("hold cycles", hold_n - h, hx);
    endtask
    task bp_case(input logic [2:0] link, input logic [31:0] flow, input logic x);
        apb(1, `MPFC_LINK_IDX, link);
        wflow(flow);
        apb(1, `MPFC_AFC_IDX, 32'h00000002);
        tick(4);
        check("back pressure", back_pressure, x);
        apb(0, `MPFC_FLOW_IDX, 0);
        check("busy half duplex", rd[0], x);
        apb(1, `MPFC_AFC_IDX, 32'h00000000);
        tick(4);
        check("back pressure off", back_pressure, 1'b0);
    endtask
    initial begin
        tick(3);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `MPFC_FLOW_IDX, 0);
        check("flow reset", rd, `MPFC_FLOW_RST);
        apb(0, 10'h3ff, 0);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h00000000);
        wflow(32'h00030000);
        wflow(32'h00030007);
        apb(0, `MPFC_FLOW_IDX, 0);
        check("flow readback", rd, 32'h00030006);
        apb(1, `MPFC_LINK_IDX, 32'h00000006);
        apb(1, `MPFC_AFC_IDX, 32'h00000001);
        tick(50);
        check("no frame tx off", mpfc_link_partner_i.nb, 0);
        apb(1, `MPFC_LINK_IDX, 32'h00000007);
        apb(0, `MPFC_FLOW_IDX, 0);
        check("busy sending", rd[0], 1'b1);
        for (int n = 0; mpfc_link_partner_i.nb < 60; n++) begin
            if (n > 2000) begin num_errors++; end_of_test; end
            @(posedge pclk);
        end
        tick(8);
        apb(0, `MPFC_FLOW_IDX, 0);
        check("busy after frame", rd, 32'h00030006);
        for (int i = 0; i < 60; i++)
            check("tx byte", mpfc_link_partner_i.frm[i], mpfc_link_partner_i.fbyte(i, 16'h0003, PT));
        apb(0, `MPFC_AFC_IDX, 0);
        check("send request cleared", rd, 32'h00000000);
        wflow(32'h00030006);
        tick(30);
        check("flow write sends nothing", mpfc_link_partner_i.nb, 60);
        rx_case(16'h0003, PT, 1'b1, 3 * `MPFC_Q100_CYC, 1'b1);
        rx_case(16'h0003, 16'h0800, 1'b1, 0, 1'b0);
        rx_case(16'h0003, PT, 1'b0, 0, 1'b0);
        mpfc_link_partner_i.send(16'h0100, PT, 1'b1);
        tick(20);
        check("hold long", tx_pause_hold, 1'b1);
        apb(0, `MPFC_STAT_IDX, 0);
        check("status hold", rd, 32'h01000002);
        // clock enable low must freeze the hold-off count
        ce <= 1'b0;
        tick(60);
        ce <= 1'b1;
        apb(0, `MPFC_STAT_IDX, 0);
        check("status frozen", rd, 32'h01000002);
        mpfc_link_partner_i.send(16'h0000, PT, 1'b1);
        tick(5);
        check("hold zero release", tx_pause_hold, 1'b0);
        wflow(32'h00030002);
        rx_case(16'h0003, PT, 1'b1, 3 * `MPFC_Q100_CYC, 1'b0);
        wflow(32'h00030000);
        rx_case(16'h0003, PT, 1'b1, 0, 1'b0);
        apb(1, `MPFC_LINK_IDX, 32'h00000003);
        wflow(32'h00010006);
        rx_case(16'h0001, PT, 1'b1, `MPFC_Q10_CYC, 1'b1);
        bp_case(3'h1, 32'h00000002, 1'b1);
        bp_case(3'h0, 32'h00000002, 1'b0);
        bp_case(3'h1, 32'h00000000, 1'b0);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
